// ===== core/mrk_top.sv
// Maintenance record keeper: identity, change counters and configuration copy
`timescale 1ns/1ps
`include "mrk_cfg.svh"

// Functional notes
// R1: Each monitored configuration function has its own change counter, stepped per change.
// R2: Counters run 0 to 255 and wrap to zero, never saturate.
// R3: Range-value counter steps on any calibration of lower or upper range.
// R4: Transfer-function counter steps on any change of transfer characteristic.
// R5: Low-current and high-current output trims step separate counters.
// R6: Zero/lower pressure trims and upper pressure trims step separate counters.
// R7: Temperature trim changes step their own counter.
// R8: Operating-mode counter steps on controller/transmitter switch, either direction.
// R9: Characterization counter steps on any table point change in trim mode.
// R10: Communication-mode counter steps on multidrop/single-unit change.
// R11: Security counter steps on password or access-level change.
// R12: Totalization counter steps on totalizer setting change or reset.
// R13: Holds a 26-character purchase order code readable by the host.
// R14: Board serial is fixed; every write to it is rejected.
// R15: Sensor serial is read-only and reloaded from a newly attached sensor.
// R16: Host rewrites the unit serial after each main-board replacement.
// R17: After a board swap, sensor config is copied to board memory before running.
// R18: On host restore request, sensor config is copied to board memory.
// R19: Swap or new sensor found by comparing stored and read sensor serial.
// R20: Counters step only on committed changes, never on refused writes.
module mrk_top #(
	parameter mrk_pkg::mrk_word_t BOARD_SN = `MRK_BOARD_SN_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire mrk_pkg::mrk_word_t pwdata,
	output mrk_pkg::mrk_word_t prdata,
	output logic pready,
	output logic pslverr,
	input wire logic wp_pin,
	input wire mrk_pkg::mrk_fn_t chg_req,
	input wire logic chg_denied,
	output logic sm_req,
	output mrk_pkg::mrk_addr_t sm_addr,
	input wire mrk_pkg::mrk_word_t sm_rdata,
	input wire logic sm_ack,
	output logic bm_we,
	output mrk_pkg::mrk_addr_t bm_addr,
	output mrk_pkg::mrk_word_t bm_wdata,
	input wire mrk_pkg::mrk_word_t bm_sensor_sn,
	output logic op_ready
);
	import mrk_pkg::*;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic wp_meta_reg, wp_sync_reg, pready_reg, pslverr_reg, lock_reg, restore_reg;
	mrk_word_t prdata_reg, unit_sn_reg, sensor_sn_reg, bm_wdata_reg, rd_next;
	mrk_word_t oc_reg [`MRK_OC_WORDS];
	mrk_state_t state_reg;
	logic [6:0] idx_reg;
	logic sm_req_reg, bm_we_reg, boot_copy_reg, sm_done;
	mrk_addr_t sm_addr_reg, bm_addr_reg;
	logic [`MRK_NUM_FN*`MRK_CNT_W-1:0] counts;
	mrk_fn_t inc_vec;
	logic dec_hit, dec_ro, dec_prot, locked, commit_ok, acc, wr_ok, oc_hit, cnt_hit;
	logic [2:0] oc_idx;
	logic [1:0] cnt_idx;

	// ****************************************
	// Write-protect pin synchroniser
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_meta_reg <= 1'b0;
			wp_sync_reg <= 1'b0;
		end else if (ce) begin
			wp_meta_reg <= wp_pin;
			wp_sync_reg <= wp_meta_reg;
		end
	end

	// Software lock and the jumper both refuse configuration writes
	assign locked = lock_reg || wp_sync_reg;

	// ****************************************
	// APB slave
	// ****************************************
	// One wait state: decode in the first access cycle, answer in the second
	assign acc = psel && penable && !pready_reg;
	assign wr_ok = psel && penable && pready_reg && pwrite && !pslverr_reg && ce;
	assign oc_idx = paddr[4:2];
	assign cnt_idx = paddr[3:2];
	assign oc_hit = (paddr[11:5] == `MRK_OC_PAGE) && (paddr[1:0] == 2'h0) &&
		(oc_idx <= `MRK_OC_LAST);
	assign cnt_hit = (paddr[11:4] == `MRK_CNT_PAGE) && (paddr[1:0] == 2'h0) &&
		(cnt_idx != 2'h3);

	always_comb begin
		rd_next = 32'h0;
		dec_hit = 1'b1;
		dec_ro = 1'b0;
		dec_prot = 1'b0;
		if (oc_hit) begin
			// R13: order code store
			rd_next = oc_reg[oc_idx];
			dec_prot = 1'b1;
		end else if (cnt_hit) begin
			rd_next = counts[{cnt_idx, 5'h00} +: 32];
			dec_ro = 1'b1;
		end else begin
			case (paddr)
				`MRK_OFF_CTRL: begin
					rd_next[`MRK_CTRL_LOCK] = lock_reg;
					rd_next[`MRK_CTRL_RESTORE] = restore_reg;
				end
				`MRK_OFF_STATUS: begin
					rd_next[`MRK_ST_RUN] = state_reg[2];
					rd_next[`MRK_ST_COPY] = state_reg[1];
					rd_next[`MRK_ST_BOOT_COPY] = boot_copy_reg;
					rd_next[`MRK_ST_LOCK] = lock_reg;
					rd_next[`MRK_ST_HW_WP] = wp_sync_reg;
					dec_ro = 1'b1;
				end
				`MRK_OFF_BOARD_SN: begin
					// R14: fixed, writes rejected
					rd_next = BOARD_SN;
					dec_ro = 1'b1;
				end
				`MRK_OFF_SENSOR_SN: begin
					rd_next = sensor_sn_reg;
					dec_ro = 1'b1;
				end
				`MRK_OFF_UNIT_SN: begin
					rd_next = unit_sn_reg;
					dec_prot = 1'b1;
				end
				default: begin
					dec_hit = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else if (ce) begin
			pready_reg <= acc;
			if (acc) begin
				prdata_reg <= pwrite ? 32'h0 : rd_next;
				pslverr_reg <= !dec_hit || (pwrite && (dec_ro || (dec_prot && locked)));
			end
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;

	// ****************************************
	// Software-written registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_reg <= 1'b0;
		end else if (wr_ok && paddr == `MRK_OFF_CTRL) begin
			lock_reg <= pwdata[`MRK_CTRL_LOCK];
		end
	end
	// A new request written while the engine takes the old one is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restore_reg <= 1'b0;
		end else if (wr_ok && paddr == `MRK_OFF_CTRL && pwdata[`MRK_CTRL_RESTORE]) begin
			restore_reg <= 1'b1;
		end else if (ce && state_reg == ST_RUN) begin
			restore_reg <= 1'b0;
		end
	end
	// Host keeps this one current after a board swap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_sn_reg <= `MRK_UNIT_SN_RST;
		end else if (wr_ok && paddr == `MRK_OFF_UNIT_SN) begin
			// R16: host rewrites unit serial
			unit_sn_reg <= pwdata;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < `MRK_OC_WORDS; gi++) begin : g_oc
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					oc_reg[gi] <= 32'h0;
				end else if (wr_ok && oc_hit && oc_idx == 3'(gi)) begin
					// R13: last word holds two chars
					oc_reg[gi] <= (3'(gi) == `MRK_OC_LAST) ? (pwdata & `MRK_OC_TAIL_MASK) : pwdata;
				end
			end
		end
	endgenerate

	// ****************************************
	// Change counting
	// ****************************************
	// R20: refused changes not counted
	assign commit_ok = !chg_denied && !locked;
	always_comb begin
		// R3: range calibration
		inc_vec[`MRK_FN_RANGE] = commit_ok && chg_req[`MRK_FN_RANGE];
		// R4: transfer function
		inc_vec[`MRK_FN_XFER] = commit_ok && chg_req[`MRK_FN_XFER];
		// R5: current trims
		inc_vec[`MRK_FN_LOW_CUR] = commit_ok && chg_req[`MRK_FN_LOW_CUR];
		inc_vec[`MRK_FN_HIGH_CUR] = commit_ok && chg_req[`MRK_FN_HIGH_CUR];
		// R6: pressure trims
		inc_vec[`MRK_FN_LOW_PRES] = commit_ok && chg_req[`MRK_FN_LOW_PRES];
		inc_vec[`MRK_FN_HIGH_PRES] = commit_ok && chg_req[`MRK_FN_HIGH_PRES];
		// R7: temperature trim
		inc_vec[`MRK_FN_TEMP] = commit_ok && chg_req[`MRK_FN_TEMP];
		// R8: operating mode
		inc_vec[`MRK_FN_OPMODE] = commit_ok && chg_req[`MRK_FN_OPMODE];
		// R9: characterization table
		inc_vec[`MRK_FN_CHAR] = commit_ok && chg_req[`MRK_FN_CHAR];
		// R10: communication mode
		inc_vec[`MRK_FN_COMM] = commit_ok && chg_req[`MRK_FN_COMM];
		// R11: security settings
		inc_vec[`MRK_FN_SECURITY] = commit_ok && chg_req[`MRK_FN_SECURITY];
		// R12: totalizer changes
		inc_vec[`MRK_FN_TOTAL] = commit_ok && chg_req[`MRK_FN_TOTAL];
	end

	mrk_ctr_bank u_ctr (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.inc(inc_vec),
		.counts(counts)
	);

	// ****************************************
	// Identity check and configuration copy
	// ****************************************
	// Sensor memory word arrives on sm_ack while sm_req is held
	assign sm_done = sm_req_reg && sm_ack;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_SNREAD;
			idx_reg <= 7'h00;
			sm_req_reg <= 1'b0;
			sm_addr_reg <= 8'h00;
			bm_we_reg <= 1'b0;
			bm_addr_reg <= 8'h00;
			bm_wdata_reg <= 32'h0;
			sensor_sn_reg <= 32'h0;
			boot_copy_reg <= 1'b0;
		end else if (ce) begin
			bm_we_reg <= 1'b0;
			unique case (state_reg)
				ST_SNREAD: begin
					if (sm_done) begin
						sm_req_reg <= 1'b0;
						// R15: reload sensor serial
						sensor_sn_reg <= sm_rdata;
						// R19: compare stored serial
						if (sm_rdata != bm_sensor_sn) begin
							state_reg <= ST_COPY;
							idx_reg <= 7'h00;
							boot_copy_reg <= 1'b1;
						end else begin
							state_reg <= ST_RUN;
						end
					end else begin
						sm_req_reg <= 1'b1;
						sm_addr_reg <= `MRK_SM_SN_ADDR;
					end
				end
				ST_COPY: begin
					// R17: copy before running
					if (idx_reg == `MRK_CFG_WORDS) begin
						// Stamp the serial so the next power-up does not copy again
						bm_we_reg <= 1'b1;
						bm_addr_reg <= `MRK_BM_SN_ADDR;
						bm_wdata_reg <= sensor_sn_reg;
						state_reg <= ST_RUN;
					end else if (sm_done) begin
						sm_req_reg <= 1'b0;
						bm_we_reg <= 1'b1;
						bm_addr_reg <= {1'b0, idx_reg};
						bm_wdata_reg <= sm_rdata;
						idx_reg <= idx_reg + 7'h01;
					end else begin
						sm_req_reg <= 1'b1;
						sm_addr_reg <= {1'b0, idx_reg};
					end
				end
				ST_RUN: begin
					// R18: restore on request
					if (restore_reg) begin
						state_reg <= ST_COPY;
						idx_reg <= 7'h00;
					end
				end
			endcase
		end
	end

	assign sm_req = sm_req_reg;
	assign sm_addr = sm_addr_reg;
	assign bm_we = bm_we_reg;
	assign bm_addr = bm_addr_reg;
	assign bm_wdata = bm_wdata_reg;
	assign op_ready = state_reg[2];

	// ****************************************
	// Checks
	// ****************************************
	property p_board_ro;
		psel && penable && pready && pwrite && paddr == `MRK_OFF_BOARD_SN |-> pslverr;
	endproperty
	a_board_ro: assert property (p_board_ro) else $error("board serial write accepted"); // R14
	property p_refused;
		ce && (chg_denied || locked) |=> $stable(counts);
	endproperty
	a_refused: assert property (p_refused) else $error("refused change was counted"); // R20
	property p_sn_load;
		ce && state_reg == ST_SNREAD && sm_done |=> sensor_sn_reg == $past(sm_rdata);
	endproperty
	a_sn_load: assert property (p_sn_load) else $error("sensor serial not reloaded"); // R15
	property p_swap;
		ce && state_reg == ST_SNREAD && sm_done && sm_rdata != bm_sensor_sn
			|=> state_reg == ST_COPY && !op_ready && idx_reg == 7'h00;
	endproperty
	a_swap: assert property (p_swap) else $error("swap did not start a copy"); // R19
	property p_same;
		ce && state_reg == ST_SNREAD && sm_done && sm_rdata == bm_sensor_sn |=> op_ready;
	endproperty
	a_same: assert property (p_same) else $error("matching serial did not run"); // R19
	property p_restore;
		ce && state_reg == ST_RUN && restore_reg |=> state_reg == ST_COPY ##0 !op_ready;
	endproperty
	a_restore: assert property (p_restore) else $error("restore request not taken"); // R18
	property p_copy_word;
		ce && state_reg == ST_COPY && sm_done && idx_reg != `MRK_CFG_WORDS
			|=> bm_we && bm_wdata == $past(sm_rdata) && bm_addr == {1'b0, $past(idx_reg)};
	endproperty
	a_copy_word: assert property (p_copy_word) else $error("copied word wrong"); // R17
	property p_oc_tail;
		oc_reg[6][31:16] == 16'h0000;
	endproperty
	a_oc_tail: assert property (p_oc_tail) else $error("order code beyond 26 chars"); // R13
	// The wait state only counts down on an enabled edge
	property p_apb_wait;
		ce && psel && penable && !pready |=> pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("APB answer late");

endmodule

// ===== core/mrk_cfg.svh
// Offsets, field positions, reset values and sizes of the maintenance record keeper
`ifndef MRK_CFG_SVH
`define MRK_CFG_SVH

// ****************************************
// Monitored functions
// ****************************************
`define MRK_NUM_FN 12
`define MRK_CNT_W 8
`define MRK_FN_RANGE 0
`define MRK_FN_XFER 1
`define MRK_FN_LOW_CUR 2
`define MRK_FN_HIGH_CUR 3
`define MRK_FN_LOW_PRES 4
`define MRK_FN_HIGH_PRES 5
`define MRK_FN_TEMP 6
`define MRK_FN_OPMODE 7
`define MRK_FN_CHAR 8
`define MRK_FN_COMM 9
`define MRK_FN_SECURITY 10
`define MRK_FN_TOTAL 11

// ****************************************
// Register offsets (byte addresses) and counter/order-code page numbers
// ****************************************
`define MRK_OFF_CTRL 12'h000
`define MRK_OFF_STATUS 12'h004
`define MRK_OFF_BOARD_SN 12'h008
`define MRK_OFF_SENSOR_SN 12'h00c
`define MRK_OFF_UNIT_SN 12'h010
`define MRK_CNT_PAGE 8'h02
`define MRK_OC_PAGE 7'h02

// ****************************************
// Fields
// ****************************************
`define MRK_CTRL_LOCK 0
`define MRK_CTRL_RESTORE 1
`define MRK_ST_RUN 0
`define MRK_ST_COPY 1
`define MRK_ST_BOOT_COPY 2
`define MRK_ST_LOCK 3
`define MRK_ST_HW_WP 4

// ****************************************
// Reset values and sizes
// ****************************************
`define MRK_BOARD_SN_DEF 32'h0000_0001
`define MRK_UNIT_SN_RST 32'h0000_0000
`define MRK_OC_CHARS 26
`define MRK_OC_WORDS 7
`define MRK_OC_LAST 3'h6
`define MRK_OC_TAIL_MASK 32'h0000_ffff
`define MRK_CFG_WORDS 7'h40
`define MRK_SM_SN_ADDR 8'hff
`define MRK_BM_SN_ADDR 8'hff

`endif

// ===== core/mrk_pkg.sv
// Types shared by the maintenance record keeper files
package mrk_pkg;
	typedef logic [31:0] mrk_word_t;
	typedef logic [7:0] mrk_addr_t;
	typedef logic [11:0] mrk_fn_t;
	typedef enum logic [2:0] {
		ST_SNREAD = 3'h1,
		ST_COPY = 3'h2,
		ST_RUN = 3'h4
	} mrk_state_t;
endpackage

// ===== core/mrk_ctr_bank.sv
// Bank of wrapping change counters, one per monitored function
`timescale 1ns/1ps
`include "mrk_cfg.svh"

module mrk_ctr_bank (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire mrk_pkg::mrk_fn_t inc,
	output logic [`MRK_NUM_FN*`MRK_CNT_W-1:0] counts
);
	import mrk_pkg::*;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [`MRK_CNT_W-1:0] cnt_reg [`MRK_NUM_FN];

	genvar g;
	generate
		for (g = 0; g < `MRK_NUM_FN; g++) begin : g_cnt
			// R1: one counter each
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_reg[g] <= 8'h00;
				end else if (ce && inc[g]) begin
					// R2: wraps past ff
					cnt_reg[g] <= cnt_reg[g] + 8'h01;
				end
			end
			assign counts[g*`MRK_CNT_W +: `MRK_CNT_W] = cnt_reg[g];

			property p_step;
				ce && inc[g] |=> cnt_reg[g] == 8'($past(cnt_reg[g]) + 8'h01);
			endproperty
			a_step: assert property (p_step) else $error("counter did not step"); // R1
		end
	endgenerate

	property p_wrap;
		ce && inc[0] && cnt_reg[0] == 8'hff |=> cnt_reg[0] == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero"); // R2

endmodule

// ===== bench/mrk_sensor_mem.sv
// Sensor module memory model answering word reads from the record keeper
`timescale 1ns/1ps

module mrk_sensor_mem (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sm_req,
	input wire mrk_pkg::mrk_addr_t sm_addr,
	input wire mrk_pkg::mrk_word_t sensor_sn,
	input wire logic [3:0] lag,
	output mrk_pkg::mrk_word_t sm_rdata,
	output logic sm_ack
);
	import mrk_pkg::*;
	logic [3:0] wait_reg;

	// ****************************************
	// Word answers
	// ****************************************
	// serial and saved words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_reg <= 4'h0;
			sm_ack <= 1'b0;
			sm_rdata <= 32'h0;
		end else if (sm_req && !sm_ack && wait_reg >= lag) begin
			sm_ack <= 1'b1;
			sm_rdata <= (sm_addr == 8'hff) ? sensor_sn : {8'h5a, sm_addr, ~sm_addr, sm_addr};
		end else begin
			// Stale data flips every cycle so a late sample cannot pass by luck
			sm_ack <= 1'b0;
			sm_rdata <= ~sm_rdata;
			wait_reg <= (sm_req && !sm_ack) ? wait_reg + 4'h1 : 4'h0;
		end
	end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the maintenance record keeper
`timescale 1ns/1ps
`include "mrk_cfg.svh"

module testbench;
	import mrk_pkg::*;
	// Arbitrary board serial
	localparam mrk_word_t BSN = 32'h1357_9bdf;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wp_pin;
	logic chg_denied, sm_req, sm_ack, bm_we, op_ready, last_err, locked, ce;
	logic [11:0] paddr;
	logic [3:0] lag;
	mrk_fn_t chg_req;
	mrk_addr_t sm_addr, bm_addr;
	mrk_word_t pwdata, prdata, sm_rdata, bm_wdata, bm_sensor_sn, sens_sn, rdv;
	logic [7:0] exp_cnt [12];
	int errors = 0;
	int samples_checked = 0;
	int copied = 0;

	mrk_top #(.BOARD_SN(BSN)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wp_pin(wp_pin), .chg_req(chg_req),
		.chg_denied(chg_denied), .sm_req(sm_req), .sm_addr(sm_addr), .sm_rdata(sm_rdata),
		.sm_ack(sm_ack), .bm_we(bm_we), .bm_addr(bm_addr), .bm_wdata(bm_wdata),
		.bm_sensor_sn(bm_sensor_sn), .op_ready(op_ready));
	mrk_sensor_mem sensor (.pclk(pclk), .presetn(presetn), .sm_req(sm_req), .sm_addr(sm_addr),
		.sensor_sn(sens_sn), .lag(lag), .sm_rdata(sm_rdata), .sm_ack(sm_ack));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ****************************************
	// Checking and access tasks
	// ****************************************
	function automatic mrk_word_t cfg_word(input mrk_addr_t a);
		return {8'h5a, a, ~a, a};
	endfunction

	task automatic summarize();
		if (errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic hang();
		errors++;
		$display("BAD %0t: wait ran out", $time);
		summarize();
	endtask

	task automatic chk(input mrk_word_t seen, input mrk_word_t exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// Request held until pready is seen high, then released at that same edge, with one idle edge after
	task automatic acc(input logic w, input logic [11:0] a, input mrk_word_t d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) hang();
		rdv = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input mrk_word_t d, input logic e);
		acc(1'b1, a, d);
		chk(32'(last_err), 32'(e));
	endtask

	task automatic rd(input logic [11:0] a, input mrk_word_t d, input logic e);
		acc(1'b0, a, 32'h0);
		chk(32'(last_err), 32'(e));
		if (!e) chk(rdv, d);
	endtask

	task automatic pulse(input mrk_fn_t m, input logic den, input int n);
		chg_req <= m;
		chg_denied <= den;
		repeat (n) @(posedge pclk);
		chg_req <= 12'h0;
		chg_denied <= 1'b0;
		@(posedge pclk);
		for (int i = 0; i < 12; i++) begin
			if (m[i] && !den && !locked && ce) exp_cnt[i] = exp_cnt[i] + 8'(n);
		end
	endtask

	task automatic check_cnt();
		for (int w = 0; w < 3; w++) begin
			rd(12'h020 + 12'(4 * w), {exp_cnt[4 * w + 3], exp_cnt[4 * w + 2],
				exp_cnt[4 * w + 1], exp_cnt[4 * w]}, 1'b0);
		end
	endtask

	task automatic wait_copies(input int target);
		int n;
		n = 0;
		while ((copied < target || op_ready !== 1'b1) && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) hang();
		// Room for the trailing serial write and status update
		repeat (3) @(posedge pclk);
	endtask

	task automatic boot(input mrk_word_t s, input mrk_word_t b);
		int base;
		base = copied;
		presetn <= 1'b0;
		sens_sn <= s;
		bm_sensor_sn <= b;
		for (int i = 0; i < 12; i++) exp_cnt[i] = 8'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		wait_copies(base + (s !== b ? 64 : 0));
		chk(32'(copied - base), s !== b ? 32'h40 : 32'h0);
		rd(`MRK_OFF_STATUS, s !== b ? 32'h5 : 32'h1, 1'b0);
		rd(`MRK_OFF_SENSOR_SN, s, 1'b0);
	endtask

	// Every board memory write is checked: copied words against the expected copy order, the serial stamp at 8'hff against sens_sn
	always @(posedge pclk) begin
		if (bm_we === 1'b1 && bm_addr === 8'hff) begin
			chk(bm_wdata, sens_sn);
		end else if (bm_we === 1'b1) begin
			chk(32'(bm_addr), 32'(copied % 64));
			chk(bm_wdata, cfg_word(8'(copied % 64)));
			copied++;
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		wp_pin = 1'b0;
		chg_req = 12'h0;
		chg_denied = 1'b0;
		lag = 4'h0;
		ce = 1'b1;
		sens_sn = 32'h0;
		bm_sensor_sn = 32'h0;
		locked = 1'b0;
		@(posedge pclk);
		boot(32'h0000_7a11, 32'h0000_0000);
		rd(`MRK_OFF_CTRL, 32'h0, 1'b0);
		check_cnt();
		rd(`MRK_OFF_BOARD_SN, BSN, 1'b0);
		wr(`MRK_OFF_BOARD_SN, ~BSN, 1'b1);
		rd(`MRK_OFF_BOARD_SN, BSN, 1'b0);
		wr(`MRK_OFF_SENSOR_SN, 32'h0, 1'b1);
		wr(12'h0fc, 32'h1, 1'b1);
		for (int i = 0; i < 12; i++) pulse(12'(1 << i), 1'b0, i + 1);
		check_cnt();
		pulse(12'hfff, 1'b0, 255);
		check_cnt();
		pulse(12'hfff, 1'b1, 3);
		// Frozen clock enable: changes offered meanwhile must not count
		ce <= 1'b0;
		pulse(12'h3c3, 1'b0, 4);
		ce <= 1'b1;
		wr(`MRK_OFF_CTRL, 32'h1, 1'b0);
		locked = 1'b1;
		pulse(12'h0a5, 1'b0, 2);
		wr(`MRK_OFF_UNIT_SN, 32'h1, 1'b1);
		rd(`MRK_OFF_STATUS, 32'hd, 1'b0);
		wr(`MRK_OFF_CTRL, 32'h0, 1'b0);
		locked = 1'b0;
		check_cnt();
		wr(`MRK_OFF_UNIT_SN, 32'h2468_ace0, 1'b0);
		rd(`MRK_OFF_UNIT_SN, 32'h2468_ace0, 1'b0);
		for (int w = 0; w < 7; w++) wr(12'h040 + 12'(4 * w), 32'h4142_4344 + 32'(w), 1'b0);
		for (int w = 0; w < 7; w++) begin
			rd(12'h040 + 12'(4 * w), (32'h4142_4344 + 32'(w)) &
				(w == 6 ? 32'h0000_ffff : 32'hffff_ffff), 1'b0);
		end
		wp_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		wr(`MRK_OFF_UNIT_SN, 32'h0, 1'b1);
		wp_pin <= 1'b0;
		lag <= 4'h3;
		repeat (3) @(posedge pclk);
		wr(`MRK_OFF_CTRL, 32'h2, 1'b0);
		wait_copies(128);
		rd(`MRK_OFF_STATUS, 32'h5, 1'b0);
		rd(`MRK_OFF_CTRL, 32'h0, 1'b0);
		lag <= 4'h0;
		boot(32'h0000_7a11, 32'h0000_7a11);
		check_cnt();
		rd(`MRK_OFF_UNIT_SN, 32'h0, 1'b0);
		boot(32'h0000_3c3c, 32'h0000_7a11);
		summarize();
	end
endmodule
